// ---- rtl/scm_pin_sync.sv ----
// three-flop synchroniser with agreement filter for asynchronous pins
// assumes each pin toggles slower than half the system clock
`default_nettype none
module scm_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins
  input  wire logic [W-1:0] pin,
  // filtered level and rising-edge pulse
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;

  // level moves only when second and third stages agree
  always_comb begin
    nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
  assign rise  = nxt_lvl & ~lvl_ff;
endmodule // scm_pin_sync
`default_nettype wire

// ---- rtl/scm_pkg.sv ----
// constants, types and register map of the serializer clock mode select block
// assumes one 50 MHz system clock and a word-addressed avalon-mm register port
`default_nettype none
package scm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] SCM_IDX_MODE   = 8'h03;
  localparam logic [7:0] SCM_IDX_OSC    = 8'h05;
  localparam logic [7:0] SCM_IDX_MULT   = 8'h06;
  localparam logic [7:0] SCM_IDX_NDIV   = 8'h07;
  localparam logic [7:0] SCM_IDX_STATUS = 8'h08;
  // field positions
  localparam int SCM_MODE_LSB   = 0;
  localparam int SCM_OVR_BIT    = 4;
  localparam int SCM_OSC_BIT    = 3;
  localparam int SCM_PRESC_LSB  = 0;
  localparam int SCM_MULT_LSB   = 2;
  // mode codes
  localparam logic [2:0] SCM_MODE_SYNC = 3'h0;
  localparam logic [2:0] SCM_MODE_EXT  = 3'h2;
  localparam logic [2:0] SCM_MODE_INT  = 3'h3;
  localparam logic [2:0] SCM_MODE_DVP  = 3'h5;
  // prescaler codes
  localparam logic [1:0] SCM_PRESC_4  = 2'h0;
  localparam logic [1:0] SCM_PRESC_8  = 2'h1;
  localparam logic [1:0] SCM_PRESC_16 = 2'h2;
  // reset values
  localparam logic [2:0] SCM_RST_MODE  = SCM_MODE_SYNC;
  localparam logic [1:0] SCM_RST_PRESC = SCM_PRESC_4;
  localparam logic [5:0] SCM_RST_MULT  = 6'h01;
  localparam logic [7:0] SCM_RST_NDIV  = 8'h01;
  // forward rate and video budget, in multiples of the reference
  localparam logic [7:0] SCM_FC_SYNC  = 8'ha0;
  localparam logic [7:0] SCM_CSI_SYNC = 8'h80;
  localparam logic [7:0] SCM_FC_EXT   = 8'h50;
  localparam logic [7:0] SCM_CSI_EXT  = 8'h40;
  localparam logic [7:0] SCM_FC_DVP   = 8'h1c;
  localparam logic [7:0] SCM_CSI_DVP  = 8'h12;
  // timing counts
  localparam logic [3:0] SCM_STABLE_EDGES = 4'h8;
  // the pin filter needs four edges after reset before the strap level is valid
  localparam logic [2:0] SCM_STRAP_WAIT   = 3'h4;
  // reference source select
  typedef enum logic [1:0] {SCM_SRC_BC, SCM_SRC_EXT, SCM_SRC_INT} scm_src_t;
  typedef enum logic {SCM_ST_HOLD, SCM_ST_RUN} scm_state_t;
  typedef struct packed {
    logic       ovr;
    logic [2:0] mode;
    logic       osc_sel;
    logic [1:0] presc;
    logic [5:0] mult;
    logic [7:0] ndiv;
  } scm_cfg_t;
  typedef struct packed {
    logic       fc_tick;
    logic       fc_gen_rst_n;
    logic       sensor_clk;
    logic       sensor_clk_en;
    logic       osc_en;
    logic       shared_domain;
    logic [7:0] fc_rate_mult;
    logic [7:0] csi_budget_mult;
  } scm_clk_out_t;
endpackage
`default_nettype wire

// ---- rtl/scm_top.sv ----
// clock mode select: reference mux, forward tick and sensor clock generator
// assumes reference pins slower than clk/2 and an avalon-mm master on one clock
`default_nettype none
module scm_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // avalon-mm slave, word addressed
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // pins
  input  wire logic [2:0]            mode_strap,
  input  wire logic                  bc_ref_clk,
  input  wire logic                  external_reference_input,
  input  wire logic                  osc_ref_clk,
  // clock outputs
  output scm_pkg::scm_clk_out_t      clk_out
);
  import scm_pkg::*;

  function automatic scm_src_t src_of(input logic [2:0] m);
    case (m)
      SCM_MODE_EXT, SCM_MODE_DVP: src_of = SCM_SRC_EXT;
      SCM_MODE_INT:               src_of = SCM_SRC_INT;
      default:                    src_of = SCM_SRC_BC;
    endcase
  endfunction

  function automatic logic [4:0] presc_val(input logic [1:0] c);
    case (c)
      SCM_PRESC_8:  presc_val = 5'd8;
      SCM_PRESC_16: presc_val = 5'd16;
      default:      presc_val = 5'd4; // reserved code falls back to 4
    endcase
  endfunction

  // reset release through two flops
  logic rst_q1_ff, rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_q1_ff <= 1'b1;
      rst_n     <= rst_q1_ff;
    end
  end

  logic [5:0] pin_lvl, pin_rise;
  scm_pin_sync #(.W(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({mode_strap, osc_ref_clk, external_reference_input, bc_ref_clk}),
    .level (pin_lvl),
    .rise  (pin_rise)
  );

  // register file and strap capture
  scm_cfg_t   cfg_ff, nxt_cfg;
  logic [2:0] strap_cnt_ff, nxt_strap_cnt;
  logic       strap_done_ff, nxt_strap_done;
  logic       ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic       run;
  logic       req, wr_take;
  assign req     = avs_read | avs_write;
  assign wr_take = avs_write & ack_ff & avs_byteenable[0];
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  always_comb begin
    nxt_cfg        = cfg_ff;
    nxt_strap_cnt  = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_ack        = req & ~ack_ff;
    nxt_rdata      = rdata_ff;
    if (!strap_done_ff) begin
      if (strap_cnt_ff == SCM_STRAP_WAIT) begin
        nxt_cfg.mode   = pin_lvl[5:3];
        nxt_strap_done = 1'b1;
      end else begin
        nxt_strap_cnt = strap_cnt_ff + 3'd1;
      end
    end
    if (wr_take) begin
      case (avs_address)
        SCM_IDX_MODE: begin
          nxt_cfg.ovr = avs_writedata[SCM_OVR_BIT];
          // mode field writable only while override bit already set
          if (cfg_ff.ovr) nxt_cfg.mode = avs_writedata[SCM_MODE_LSB +: 3];
        end
        SCM_IDX_OSC:  nxt_cfg.osc_sel = avs_writedata[SCM_OSC_BIT];
        SCM_IDX_MULT: begin
          nxt_cfg.presc = avs_writedata[SCM_PRESC_LSB +: 2];
          nxt_cfg.mult  = avs_writedata[SCM_MULT_LSB +: 6];
        end
        SCM_IDX_NDIV: nxt_cfg.ndiv = avs_writedata[7:0];
        default: ;
      endcase
    end
    if (avs_read & ~ack_ff) begin
      case (avs_address)
        SCM_IDX_MODE:   nxt_rdata = {27'h0, cfg_ff.ovr, 1'b0, cfg_ff.mode};
        SCM_IDX_OSC:    nxt_rdata = {28'h0, cfg_ff.osc_sel, 3'h0};
        SCM_IDX_MULT:   nxt_rdata = {24'h0, cfg_ff.mult, cfg_ff.presc};
        SCM_IDX_NDIV:   nxt_rdata = {24'h0, cfg_ff.ndiv};
        SCM_IDX_STATUS: nxt_rdata = {26'h0, clk_out.shared_domain, clk_out.sensor_clk_en,
                                     cfg_ff.mode, run};
        default:        nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff        <= '{ovr: 1'b0, mode: SCM_RST_MODE, osc_sel: 1'b0, presc: SCM_RST_PRESC,
                         mult: SCM_RST_MULT, ndiv: SCM_RST_NDIV};
      strap_cnt_ff  <= 3'h0;
      strap_done_ff <= 1'b0;
      ack_ff        <= 1'b0;
      rdata_ff      <= 32'h0;
    end else begin
      cfg_ff        <= nxt_cfg;
      strap_cnt_ff  <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      ack_ff        <= nxt_ack;
      rdata_ff      <= nxt_rdata;
    end
  end

  // reference mux and forward-channel generator hold
  scm_src_t   sel_ff, nxt_sel;
  logic [2:0] mode_seen_ff, nxt_mode_seen;
  scm_state_t st_ff, nxt_st;
  logic [3:0] edge_cnt_ff, nxt_edge_cnt;
  logic       half_ff, nxt_half;
  logic       ref_tick, half_rate, fc_go;
  logic [1:0] sel_idx;
  assign sel_idx   = 2'(sel_ff);
  assign ref_tick  = pin_rise[sel_idx];
  assign run       = (st_ff == SCM_ST_RUN);
  // half-rate oscillator setting passes every second reference edge
  assign half_rate = (sel_ff == SCM_SRC_INT) & ~cfg_ff.osc_sel;
  assign fc_go     = run & ref_tick & (~half_rate | half_ff);

  always_comb begin
    nxt_sel       = sel_ff;
    nxt_mode_seen = mode_seen_ff;
    nxt_st        = st_ff;
    nxt_edge_cnt  = edge_cnt_ff;
    nxt_half      = half_ff;
    if (cfg_ff.mode != mode_seen_ff) begin
      nxt_mode_seen = cfg_ff.mode;
      nxt_sel       = src_of(cfg_ff.mode);
      nxt_st        = SCM_ST_HOLD;
      nxt_edge_cnt  = 4'h0;
      nxt_half      = 1'b0;
    end else begin
      case (st_ff)
        SCM_ST_HOLD: if (ref_tick) begin
          // a missing reference keeps the generator held
          nxt_edge_cnt = edge_cnt_ff + 4'h1;
          if (nxt_edge_cnt == SCM_STABLE_EDGES) nxt_st = SCM_ST_RUN;
        end
        SCM_ST_RUN: if (ref_tick) nxt_half = ~half_ff;
        default: nxt_st = SCM_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff       <= SCM_SRC_BC;
      mode_seen_ff <= SCM_RST_MODE;
      st_ff        <= SCM_ST_HOLD;
      edge_cnt_ff  <= 4'h0;
      half_ff      <= 1'b0;
    end else begin
      sel_ff       <= nxt_sel;
      mode_seen_ff <= nxt_mode_seen;
      st_ff        <= nxt_st;
      edge_cnt_ff  <= nxt_edge_cnt;
      half_ff      <= nxt_half;
    end
  end

  // sensor clock: fractional divider fed by the forward tick
  logic [15:0] acc_ff, nxt_acc, sum, limit;
  logic        sclk_ff, nxt_sclk;
  logic        sclk_allowed;
  logic [7:0]  ndiv_eff;
  scm_clk_out_t out_ff, nxt_out;
  assign ndiv_eff     = (cfg_ff.ndiv == 8'h00) ? 8'h01 : cfg_ff.ndiv;
  assign limit        = 16'(presc_val(cfg_ff.presc)) * 16'(ndiv_eff);
  assign sum          = acc_ff + 16'(cfg_ff.mult);
  assign sclk_allowed = run & (sel_ff != SCM_SRC_INT);

  always_comb begin
    nxt_acc  = acc_ff;
    nxt_sclk = sclk_ff;
    if (!sclk_allowed) begin
      nxt_acc  = 16'h0;
      nxt_sclk = 1'b0;
    end else if (fc_go) begin
      if (sum >= limit) begin
        nxt_acc  = sum - limit;
        nxt_sclk = ~sclk_ff;
      end else begin
        nxt_acc = sum;
      end
    end
    nxt_out.fc_tick       = fc_go;
    nxt_out.fc_gen_rst_n  = run;
    nxt_out.sensor_clk    = nxt_sclk;
    nxt_out.sensor_clk_en = sclk_allowed;
    nxt_out.osc_en        = (sel_ff == SCM_SRC_INT);
    nxt_out.shared_domain = (sel_ff == SCM_SRC_BC);
    // forward rate multiple always above the video budget
    case (cfg_ff.mode)
      SCM_MODE_EXT, SCM_MODE_INT: begin
        nxt_out.fc_rate_mult    = SCM_FC_EXT;
        nxt_out.csi_budget_mult = SCM_CSI_EXT;
      end
      SCM_MODE_DVP: begin
        nxt_out.fc_rate_mult    = SCM_FC_DVP;
        nxt_out.csi_budget_mult = SCM_CSI_DVP;
      end
      default: begin
        nxt_out.fc_rate_mult    = SCM_FC_SYNC;
        nxt_out.csi_budget_mult = SCM_CSI_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff  <= 16'h0;
      sclk_ff <= 1'b0;
      out_ff  <= '0;
    end else begin
      acc_ff  <= nxt_acc;
      sclk_ff <= nxt_sclk;
      out_ff  <= nxt_out;
    end
  end

  assign clk_out = out_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mode_change_holds: assert property (
    (cfg_ff.mode != mode_seen_ff) |=> ##1 !clk_out.fc_gen_rst_n)
    else $error("generator not held after mode change");
  a_hold_no_tick: assert property (
    !run |=> !clk_out.fc_tick)
    else $error("forward tick while generator held");
  a_internal_no_sclk: assert property (
    (sel_ff == SCM_SRC_INT) |=> !clk_out.sensor_clk_en && !clk_out.sensor_clk)
    else $error("sensor clock active in internal mode");
  a_sync_uses_bc: assert property (
    (cfg_ff.mode == SCM_MODE_SYNC && mode_seen_ff == SCM_MODE_SYNC) |->
      sel_ff == SCM_SRC_BC)
    else $error("sync mode not on back-channel reference");
  a_ext_uses_pin: assert property (
    (cfg_ff.mode == SCM_MODE_EXT && mode_seen_ff == SCM_MODE_EXT) |->
      sel_ff == SCM_SRC_EXT)
    else $error("external mode not on external reference");
  a_sync_no_osc: assert property (
    (sel_ff == SCM_SRC_BC) |=> !clk_out.osc_en && clk_out.shared_domain)
    else $error("oscillator on or domain split in sync mode");
  a_fc_above_video: assert property (
    $past(rst_n) |-> clk_out.fc_rate_mult > clk_out.csi_budget_mult)
    else $error("forward rate not above video budget");
  a_strap_taken: assert property (
    (!strap_done_ff && strap_cnt_ff == SCM_STRAP_WAIT) |=> cfg_ff.mode == $past(pin_lvl[5:3]))
    else $error("strap mode not captured");
  a_presc_reset: assert property (
    $rose(rst_n) |-> presc_val(cfg_ff.presc) == 5'd4)
    else $error("prescaler default not four");
  a_sclk_limit: assert property (
    (sclk_allowed && fc_go && sum < limit) |=> $stable(sclk_ff) && acc_ff == $past(sum))
    else $error("sensor clock toggled below threshold");
  a_bus_answer: assert property (
    (req && !ack_ff) |=> !avs_waitrequest || !req)
    else $error("waitrequest held past one cycle");
endmodule // scm_top
`default_nettype wire

// ---- tb/scm_far_end.sv ----
// far side: back-channel reference from the paired deserializer, plus module clocks
// assumes timeunit 1ns; a stopped source holds its pin low, it does not freeze high
`default_nettype none
module scm_far_end (
  // source controls: [0] back channel, [1] external, [2] oscillator
  input  wire logic [2:0] run,
  input  wire logic       slow,
  // reference pins
  output logic            bc_ref_clk,
  output logic            external_reference_input,
  output logic            osc_ref_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bc_ref_clk = 1'b0;
    external_reference_input = 1'b0;
    osc_ref_clk = 1'b0;
  end
  // deserializer sends its reference over the back channel
  always #(slow ? 160 : 60) bc_ref_clk = run[0] ? ~bc_ref_clk : 1'b0;
  // module supplies a clock on the pin in external modes
  always #(slow ? 170 : 70) external_reference_input = run[1] ? ~external_reference_input : 1'b0;
  always #(slow ? 150 : 50) osc_ref_clk = run[2] ? ~osc_ref_clk : 1'b0;
endmodule // scm_far_end
`default_nettype wire

// ---- tb/tb_scm_top.sv ----
// self-checking bench for scm_top: strap modes, register port, clock outputs
// assumes scm_far_end drives the three reference pins
`default_nettype none
module tb_scm_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scm_pkg::*;
  logic         clk = 1'b0;
  logic         rstn;
  logic [7:0]   avs_address = 8'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [2:0]   mode_strap = 3'h0;
  logic [2:0]   run = 3'h0;
  logic         slow = 1'b0;
  logic         bc_ref_clk, external_reference_input, osc_ref_clk;
  scm_clk_out_t clk_out;
  int           n_fail = 0, checked = 0, ticks = 0, tog = 0;
  int           edges[3] = '{0, 0, 0};

  always #10 clk = ~clk;
  always @(posedge clk) if (clk_out.fc_tick === 1'b1) ticks++;
  always @(clk_out.sensor_clk) tog++;
  always @(posedge bc_ref_clk) edges[0]++;
  always @(posedge external_reference_input) edges[1]++;
  always @(posedge osc_ref_clk) edges[2]++;

  scm_top dut_u (
    .clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mode_strap(mode_strap), .bc_ref_clk(bc_ref_clk),
    .external_reference_input(external_reference_input),
    .osc_ref_clk(osc_ref_clk), .clk_out(clk_out)
  );
  scm_far_end far_u (
    .run(run), .slow(slow), .bc_ref_clk(bc_ref_clk),
    .external_reference_input(external_reference_input), .osc_ref_clk(osc_ref_clk)
  );

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_near(input string nm, input int e, input int g, input int tol);
    checked++;
    if (g < e - tol || g > e + tol) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("unexpected wait: expected completion, seen timeout");
    results();
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic be, output logic [31:0] q);
    int i;
    i = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h0, be};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      i++;
      if (i > 50) hang();
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 1'b1, q);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 1'b1, q);
    chk_val(nm, {24'h0, e}, q);
  endtask
  task automatic do_reset(input logic [2:0] m);
    mode_strap <= m;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk_val("clk_out in reset", 32'h0, {10'h0, clk_out});
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic wait_run(input int s, input int e0, output int c);
    int i;
    i = 0;
    while (clk_out.fc_gen_rst_n !== 1'b1) begin
      i++;
      if (i > 5000) hang();
      @(posedge clk);
    end
    c = edges[s] - e0;
  endtask
  // ticks and sensor clock changes seen while source s makes n rising edges
  task automatic window(input int s, input int n, output int t, output int g);
    int e0, t0, g0, i;
    e0 = edges[s];
    t0 = ticks;
    g0 = tog;
    i = 0;
    while (edges[s] - e0 < n) begin
      i++;
      if (i > 40000) hang();
      @(posedge clk);
    end
    t = ticks - t0;
    g = tog - g0;
  endtask
  function automatic int f_src(input logic [2:0] m);
    return (m == SCM_MODE_SYNC) ? 0 : (m == SCM_MODE_INT) ? 2 : 1;
  endfunction
  function automatic logic [15:0] f_rates(input logic [2:0] m);
    if (m == SCM_MODE_SYNC) return {8'ha0, 8'h80};
    if (m == SCM_MODE_DVP) return {8'h1c, 8'h12};
    return {8'h50, 8'h40};
  endfunction

  initial begin
    logic [2:0]  modes[4];
    logic [31:0] q, ex, gt;
    int          s, t, g, c, e0, mm, nn, dv;
    modes = '{SCM_MODE_SYNC, SCM_MODE_EXT, SCM_MODE_INT, SCM_MODE_DVP};
    void'($urandom(44004));
    foreach (modes[k]) begin
      s = f_src(modes[k]);
      run <= 3'(1 << s);
      e0 = edges[s];
      do_reset(modes[k]);
      if (modes[k] == SCM_MODE_INT) wr(SCM_IDX_OSC, 8'h08);
      wait_run(s, e0, c);
      chk_val("edges before run", 32'h1, 32'(c >= 8));
      rdchk("mode", SCM_IDX_MODE, {5'h0, modes[k]});
      ex = {26'h0, modes[k] == SCM_MODE_SYNC, modes[k] != SCM_MODE_INT, modes[k], 1'b1};
      rdchk("status", SCM_IDX_STATUS, ex[7:0]);
      ex = {13'h0, modes[k] != SCM_MODE_INT, modes[k] == SCM_MODE_INT,
            modes[k] == SCM_MODE_SYNC, f_rates(modes[k])};
      gt = {13'h0, clk_out.sensor_clk_en, clk_out.osc_en, clk_out.shared_domain,
            clk_out.fc_rate_mult, clk_out.csi_budget_mult};
      chk_val("clock flags", ex, gt);
      chk_val("rate above budget", 32'h1, 32'(gt[15:8] > gt[7:0]));
      chk_val("video budget nonzero", 32'h1, 32'(gt[7:0] != 8'h00));
      window(s, 40, t, g);
      chk_near("ticks per edge", 40, t, 1);
      if (modes[k] == SCM_MODE_INT) begin
        chk_val("sensor clock idle", 32'h0, 32'(g));
        wr(SCM_IDX_OSC, 8'h00);
        window(s, 40, t, g);
        chk_near("half-rate ticks", 20, t, 1);
      end
      run <= 3'(~(1 << s));
      repeat (10) @(posedge clk);
      t = ticks;
      repeat (1000) @(posedge clk);
      chk_val("ticks from other source", 32'h0, 32'(ticks - t));
    end
    slow <= 1'b1;
    run <= 3'h7;
    do_reset(SCM_MODE_SYNC);
    rdchk("prescaler reset", SCM_IDX_MULT, 8'h04);
    rdchk("divider reset", SCM_IDX_NDIV, 8'h01);
    rdchk("osc select reset", SCM_IDX_OSC, 8'h00);
    wait_run(0, 0, c);
    wr(SCM_IDX_MODE, 8'h02);
    rdchk("mode without override", SCM_IDX_MODE, 8'h00);
    wr(SCM_IDX_MODE, 8'h10);
    e0 = edges[1];
    wr(SCM_IDX_MODE, 8'h12);
    c = 0;
    repeat (4) begin
      @(posedge clk);
      if (clk_out.fc_gen_rst_n === 1'b0) c = 1;
    end
    chk_val("hold after switch", 32'h1, 32'(c));
    wait_run(1, e0, c);
    chk_near("edges to run", 9, c, 1);
    rdchk("status ext", SCM_IDX_STATUS, 8'h15);
    bus(1'b1, SCM_IDX_MODE, 8'h13, 1'b0, q);
    rdchk("mode lane off", SCM_IDX_MODE, 8'h12);
    wr(8'h20, 8'hff);
    rdchk("unmapped", 8'h20, 8'h00);
    slow <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      mm = $urandom_range(4, 1);
      nn = $urandom_range(4, 1);
      dv = (p == 1) ? 8 : (p == 2) ? 16 : 4;
      wr(SCM_IDX_MULT, {mm[5:0], p[1:0]});
      wr(SCM_IDX_NDIV, nn[7:0]);
      rdchk("prescaler", SCM_IDX_MULT, {mm[5:0], p[1:0]});
      // let residue of the old setting drain out of the accumulator
      window(1, 64, t, g);
      window(1, 512, t, g);
      chk_near("sensor toggles", 512 * mm / (dv * nn), g, 2);
    end
    results();
  end
endmodule // tb_scm_top
`default_nettype wire
